/* nmsm_checker_assertions.sv */
// checker of indicator timing for the status and mode block
`timescale 1ns/10ps
`default_nettype none
module nmsm_checker #(
  parameter integer CONNS = 8
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // watched inputs
  input wire watchdogError,
  input wire cmdSent,
  input wire cmdReceived,
  input wire commError,
  input wire hostXferActive,
  input wire [CONNS-1:0] connectionOpenedFlags,
  // watched outputs
  input wire runIndicator,
  input wire readyIndicator,
  input wire activityIndicator,
  input wire [CONNS-1:0] connectionOpenIndicators,
  input wire [CONNS-1:0] connDataGrant,
  input wire loopTestActiveIndicator,
  input wire loopFaultIndicator,
  input wire ramTestActiveIndicator,
  input wire ramFaultIndicator,
  input wire romTestActiveIndicator,
  input wire romFaultIndicator,
  input wire commFaultIndicator,
  input wire hostTransferIndicator,
  input wire watchdogFaultFlag,
  input wire networkConnected
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_conn_mirror: assert property (
    $changed(connectionOpenedFlags) |=> connectionOpenIndicators == $past(connectionOpenedFlags))
    else $error("connection lights do not follow flags");
  chk_xfer_follow: assert property ($rose(hostXferActive) |=> $rose(hostTransferIndicator))
    else $error("transfer light late");
  chk_grant_open: assert property ((connDataGrant & ~$past(connectionOpenedFlags)) == '0)
    else $error("grant on closed connection");
  chk_wdog_fault: assert property (
    watchdogError |-> ##[1:2] (watchdogFaultFlag && !runIndicator))
    else $error("watchdog error not shown");
  chk_wdog_hold: assert property (watchdogFaultFlag |=> watchdogFaultFlag && !runIndicator)
    else $error("watchdog flag dropped");
  chk_comm_cause: assert property (
    $rose(commFaultIndicator) |-> $past(commError) || $past(commError, 2))
    else $error("comm fault without error");
  chk_busy_cause: assert property (
    $rose(activityIndicator) |-> $past(cmdSent, 2) || $past(cmdReceived, 2))
    else $error("busy without command");
  chk_tests_dark: assert property (networkConnected && $past(networkConnected) |->
    !(loopTestActiveIndicator || loopFaultIndicator || ramTestActiveIndicator ||
      ramFaultIndicator || romTestActiveIndicator || romFaultIndicator))
    else $error("test light in online mode");
  chk_ready_online: assert property (
    readyIndicator |-> networkConnected || $past(networkConnected))
    else $error("ready outside online mode");
endmodule

bind nmsm_top nmsm_checker #(.CONNS(CONNS)) i_chk (.clk, .rstn, .watchdogError, .cmdSent,
  .cmdReceived, .commError, .hostXferActive, .connectionOpenedFlags, .runIndicator,
  .readyIndicator, .activityIndicator, .connectionOpenIndicators, .connDataGrant,
  .loopTestActiveIndicator, .loopFaultIndicator, .ramTestActiveIndicator, .ramFaultIndicator,
  .romTestActiveIndicator, .romFaultIndicator, .commFaultIndicator, .hostTransferIndicator,
  .watchdogFaultFlag, .networkConnected);
`default_nettype wire

/* nmsm_delay_timer.v */
// startup delay counter for the ready indicator
`timescale 1ns/10ps
`default_nettype none
`include "nmsm_regs.vh"

module nmsm_delay_timer #(
  parameter [32:0] CYCLES = `NMSM_DELAY_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire run,
  input wire bypass,
  // result
  output reg done
);

  reg [32:0] countReg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      countReg <= 33'h0_0000_0000;
      done <= 1'b0;
    end else if (!run) begin
      countReg <= 33'h0_0000_0000;
      done <= 1'b0;
    end else if (bypass || countReg >= CYCLES - 33'h1) begin
      done <= 1'b1;
    end else begin
      countReg <= countReg + 33'h1;
    end
  end

endmodule
`default_nettype wire

/* nmsm_host_model.sv */
// bus master model of the controller cpu
`timescale 1ns/10ps
`default_nettype none
module nmsm_host_model (
  // clock
  input wire clk,
  // ahb-lite master
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata
);
  initial begin
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single transfer per call, never a burst
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
  endtask
endmodule
`default_nettype wire

/* nmsm_regs.vh */
// register map, field positions and timing constants of the network module status block
`ifndef NMSM_REGS_VH
`define NMSM_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define NMSM_ADDR_CTRL 8'h00
`define NMSM_ADDR_STATUS 8'h04
`define NMSM_ADDR_IRQ_STAT 8'h08
`define NMSM_ADDR_IRQ_MASK 8'h0C
`define NMSM_ADDR_CONN 8'h10

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define NMSM_CTRL_MODE_LO 0
`define NMSM_CTRL_MODE_HI 3
`define NMSM_CTRL_SW_LO 4
`define NMSM_CTRL_SW_HI 7
`define NMSM_CTRL_BANK 8
`define NMSM_CTRL_FCLR 9
`define NMSM_CTRL_START 10
`define NMSM_CTRL_RESET 32'h0000_0000

// condition switch numbers inside the switch field
`define NMSM_SW_DELAY 3

// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define NMSM_MODE_ONLINE 4'h0
`define NMSM_MODE_OFFLINE 4'h1
`define NMSM_MODE_LOOP 4'h2
`define NMSM_MODE_RAM 4'h3
`define NMSM_MODE_ROM 4'h4

// ----------------------------------------------------------------
// status and interrupt bits
// ----------------------------------------------------------------
`define NMSM_ST_RUN 0
`define NMSM_ST_READY 1
`define NMSM_ST_BUSY 2
`define NMSM_ST_WDOG 3
`define NMSM_ST_COMM 4
`define NMSM_ST_XFER 5
`define NMSM_ST_LOOPON 6
`define NMSM_ST_LOOPERR 7
`define NMSM_ST_RAMON 8
`define NMSM_ST_RAMERR 9
`define NMSM_ST_ROMON 10
`define NMSM_ST_ROMERR 11
`define NMSM_ST_BANK 12
`define NMSM_ST_OFFLINE 13
`define NMSM_ST_WIDTH 14

`define NMSM_IRQ_WDOG 0
`define NMSM_IRQ_COMM 1
`define NMSM_IRQ_TESTERR 2
`define NMSM_IRQ_READY 3
`define NMSM_IRQ_WIDTH 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NMSM_CLK_MHZ 250
`define NMSM_DELAY_SEC 20
// 33 bits wide: twenty seconds of clock overflows a 32-bit integer
`define NMSM_DELAY_CYCLES (`NMSM_DELAY_SEC * `NMSM_CLK_MHZ * 33'h0_000F_4240)

`endif

/* nmsm_sticky.v */
// sticky event bits, cleared by writing one, set wins over clear
`timescale 1ns/10ps
`default_nettype none

module nmsm_sticky #(
  parameter integer WIDTH = 4
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // events and clears
  input wire [WIDTH-1:0] setBits,
  input wire [WIDTH-1:0] clearBits,
  // state
  output reg [WIDTH-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flags[i] <= 1'b0;
        end else if (setBits[i]) begin
          flags[i] <= 1'b1;
        end else if (clearBits[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* nmsm_top.v */
// status indication and operating mode block with AHB-Lite register slave
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "nmsm_regs.vh"

module nmsm_top #(
  parameter [32:0] DELAY_CYCLES = `NMSM_DELAY_CYCLES,
  parameter integer CONNS = 8
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  // device events
  input wire watchdogError,
  input wire cmdSent,
  input wire cmdReceived,
  input wire respReceived,
  input wire respSent,
  input wire busyTimeout,
  input wire commError,
  input wire [CONNS-1:0] connectionOpenedFlags,
  input wire [CONNS-1:0] connDataRequest,
  input wire hostXferActive,
  input wire testDone,
  input wire testFail,
  // indicators
  output reg runIndicator,
  output reg readyIndicator,
  output reg activityIndicator,
  output reg [CONNS-1:0] connectionOpenIndicators,
  output reg [CONNS-1:0] connDataGrant,
  output reg loopTestActiveIndicator,
  output reg loopFaultIndicator,
  output reg ramTestActiveIndicator,
  output reg ramFaultIndicator,
  output reg romTestActiveIndicator,
  output reg romFaultIndicator,
  output reg commFaultIndicator,
  output reg hostTransferIndicator,
  output reg watchdogFaultFlag,
  output reg bankSelectSignal,
  output reg networkConnected,
  output wire irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rstSync1Reg;
  reg rstSync2Reg;
  wire rstnInt;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1Reg <= 1'b0;
      rstSync2Reg <= 1'b0;
    end else begin
      rstSync1Reg <= 1'b1;
      rstSync2Reg <= rstSync1Reg;
    end
  end
  assign rstnInt = rstSync2Reg;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg [31:0] ctrlReg;
  reg [`NMSM_IRQ_WIDTH-1:0] maskReg;
  reg wrPendReg;
  reg [7:0] wrAddrReg;
  wire [`NMSM_IRQ_WIDTH-1:0] irqFlags;
  wire [`NMSM_ST_WIDTH-1:0] statusWord;
  reg [`NMSM_IRQ_WIDTH-1:0] irqClear;
  wire addrPhase;

  // zero-wait slave: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];

  function [31:0] readMux;
    input [7:0] a;
    input [31:0] c;
    input [`NMSM_ST_WIDTH-1:0] s;
    input [`NMSM_IRQ_WIDTH-1:0] f;
    input [`NMSM_IRQ_WIDTH-1:0] m;
    input [CONNS-1:0] o;
    begin
      case (a)
        `NMSM_ADDR_CTRL: readMux = c;
        `NMSM_ADDR_STATUS: readMux = {{(32-`NMSM_ST_WIDTH){1'b0}}, s};
        `NMSM_ADDR_IRQ_STAT: readMux = {{(32-`NMSM_IRQ_WIDTH){1'b0}}, f};
        `NMSM_ADDR_IRQ_MASK: readMux = {{(32-`NMSM_IRQ_WIDTH){1'b0}}, m};
        `NMSM_ADDR_CONN: readMux = {{(32-CONNS){1'b0}}, o};
        default: readMux = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      wrPendReg <= 1'b0;
      wrAddrReg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPendReg <= addrPhase && hwrite;
      wrAddrReg <= haddr;
      if (addrPhase && !hwrite) begin
        hrdata <= readMux(haddr, ctrlReg, statusWord, irqFlags, maskReg,
          connectionOpenIndicators);
      end
    end
  end

  // mode and switch fields reset to online and all switches off
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      ctrlReg <= `NMSM_CTRL_RESET;
      maskReg <= {`NMSM_IRQ_WIDTH{1'b0}};
    end else if (wrPendReg) begin
      if (wrAddrReg == `NMSM_ADDR_CTRL) begin
        ctrlReg <= hwdata;
      end
      if (wrAddrReg == `NMSM_ADDR_IRQ_MASK) begin
        maskReg <= hwdata[`NMSM_IRQ_WIDTH-1:0];
      end
    end
  end

  always @* begin
    irqClear = {`NMSM_IRQ_WIDTH{1'b0}};
    if (wrPendReg && wrAddrReg == `NMSM_ADDR_IRQ_STAT) begin
      irqClear = hwdata[`NMSM_IRQ_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [3:0] modeSel;
  wire [3:0] condSw;
  wire started;
  wire faultClear;
  wire isOnline;
  wire isOffline;
  wire isLoop;
  wire isRam;
  wire isRom;
  wire delayDone;

  assign modeSel = ctrlReg[`NMSM_CTRL_MODE_HI:`NMSM_CTRL_MODE_LO];
  assign condSw = ctrlReg[`NMSM_CTRL_SW_HI:`NMSM_CTRL_SW_LO];
  assign started = ctrlReg[`NMSM_CTRL_START];
  assign faultClear = ctrlReg[`NMSM_CTRL_FCLR];
  // a mode counts only while the start bit is set
  function modeIs;
    input [3:0] sel;
    input go;
    input [3:0] code;
    begin
      modeIs = go && sel == code;
    end
  endfunction

  // values 5 to 9 and above match none of these, so no mode runs
  assign isOnline = modeIs(modeSel, started, `NMSM_MODE_ONLINE);
  assign isOffline = modeIs(modeSel, started, `NMSM_MODE_OFFLINE);
  assign isLoop = modeIs(modeSel, started, `NMSM_MODE_LOOP);
  assign isRam = modeIs(modeSel, started, `NMSM_MODE_RAM);
  assign isRom = modeIs(modeSel, started, `NMSM_MODE_ROM);

  nmsm_delay_timer #(
    .CYCLES(DELAY_CYCLES)
  ) u_delay (
    .clk(clk),
    .rstn(rstnInt),
    .run(isOnline),
    .bypass(!condSw[`NMSM_SW_DELAY]),
    .done(delayDone)
  );

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  localparam TEST_LOOP = 0;
  localparam TEST_RAM = 1;
  localparam TEST_ROM = 2;
  localparam TESTS = 3;

  reg [TESTS-1:0] testFailedReg;
  reg busyReg;
  wire [TESTS-1:0] testMode;
  wire testFailed;

  assign testMode = {isRom, isRam, isLoop};
  assign testFailed = testDone && testFail;

  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      runIndicator <= 1'b0;
      watchdogFaultFlag <= 1'b0;
      readyIndicator <= 1'b0;
      activityIndicator <= 1'b0;
      busyReg <= 1'b0;
      connectionOpenIndicators <= {CONNS{1'b0}};
      connDataGrant <= {CONNS{1'b0}};
      commFaultIndicator <= 1'b0;
      hostTransferIndicator <= 1'b0;
      bankSelectSignal <= 1'b0;
      networkConnected <= 1'b0;
      testFailedReg <= {TESTS{1'b0}};
      loopTestActiveIndicator <= 1'b0;
      loopFaultIndicator <= 1'b0;
      ramTestActiveIndicator <= 1'b0;
      ramFaultIndicator <= 1'b0;
      romTestActiveIndicator <= 1'b0;
      romFaultIndicator <= 1'b0;
    end else begin
      // watchdog fault is sticky until reset
      if (watchdogError) begin
        watchdogFaultFlag <= 1'b1;
      end
      runIndicator <= !watchdogError && !watchdogFaultFlag;
      readyIndicator <= isOnline && delayDone;
      // busy spans command to response or timeout, both directions
      if (cmdSent || cmdReceived) begin
        busyReg <= 1'b1;
      end else if (respReceived || respSent || busyTimeout) begin
        busyReg <= 1'b0;
      end
      activityIndicator <= busyReg && isOnline;
      connectionOpenIndicators <= connectionOpenedFlags;
      connDataGrant <= connDataRequest & connectionOpenedFlags
        & {CONNS{isOnline}};
      // clear holds the light off; a new error while held is not latched
      if (faultClear) begin
        commFaultIndicator <= 1'b0;
      end else if (commError) begin
        commFaultIndicator <= 1'b1;
      end
      hostTransferIndicator <= hostXferActive;
      bankSelectSignal <= ctrlReg[`NMSM_CTRL_BANK];
      networkConnected <= isOnline;
      // one record per test, so a failure never lights the next test's fault
      testFailedReg <= testMode & (testFailedReg | {TESTS{testFailed}});
      // test lights only while the matching test runs and has not ended
      loopTestActiveIndicator <= isLoop && !testDone;
      ramTestActiveIndicator <= isRam && !testDone;
      romTestActiveIndicator <= isRom && !testDone;
      // fault lights follow their own record while the mode stays
      loopFaultIndicator <= isLoop && (testFailedReg[TEST_LOOP] || testFailed);
      ramFaultIndicator <= isRam && (testFailedReg[TEST_RAM] || testFailed);
      romFaultIndicator <= isRom && (testFailedReg[TEST_ROM] || testFailed);
    end
  end

  // ----------------------------------------------------------------
  // status and interrupts
  // ----------------------------------------------------------------
  assign statusWord = {isOffline, bankSelectSignal, romFaultIndicator,
    romTestActiveIndicator, ramFaultIndicator, ramTestActiveIndicator,
    loopFaultIndicator, loopTestActiveIndicator, hostTransferIndicator,
    commFaultIndicator, watchdogFaultFlag, activityIndicator,
    readyIndicator, runIndicator};

  wire [`NMSM_IRQ_WIDTH-1:0] irqSet;
  // ready edge raises one interrupt per online start
  reg readyPrevReg;

  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      readyPrevReg <= 1'b0;
    end else begin
      readyPrevReg <= readyIndicator;
    end
  end

  assign irqSet = {readyIndicator && !readyPrevReg, testDone && testFail,
    commError, watchdogError};

  nmsm_sticky #(
    .WIDTH(`NMSM_IRQ_WIDTH)
  ) u_irq (
    .clk(clk),
    .rstn(rstnInt),
    .setBits(irqSet),
    .clearBits(irqClear),
    .flags(irqFlags)
  );

  // level output: stays high until software clears or masks the cause
  assign irq = |(irqFlags & maskReg);

endmodule
`default_nettype wire

/* tb_top.sv */
// testbench of the status and mode block
`timescale 1ns/10ps
`default_nettype none
`include "nmsm_regs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] ev = 8'h00;
  logic testFail = 1'b0;
  logic [7:0] connectionOpenedFlags = 8'h00;
  logic [7:0] connDataRequest = 8'h00;
  logic hostXferActive = 1'b0;
  logic [31:0] rdVal;
  int fail_count = 0;
  int compares = 0;
  int i;
  int st[3] = '{1, 5, 1};
  int en[3] = '{2, 6, 7};
  int md[6] = '{1, 5, 6, 7, 8, 9};
  wire hsel, hwrite, hreadyout, hresp, irq, runIndicator, readyIndicator, activityIndicator;
  wire loopTestActiveIndicator, loopFaultIndicator, ramTestActiveIndicator, ramFaultIndicator;
  wire romTestActiveIndicator, romFaultIndicator, commFaultIndicator, hostTransferIndicator;
  wire watchdogFaultFlag, bankSelectSignal, networkConnected;
  wire [7:0] haddr, connectionOpenIndicators, connDataGrant;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] hwdata, hrdata;

  always #2 clk = ~clk;

  // short delay count keeps the delayed start check brief
  nmsm_top #(.DELAY_CYCLES(33'h14), .CONNS(8)) i_dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .watchdogError(ev[0]),
    .cmdSent(ev[1]), .respReceived(ev[2]), .commError(ev[3]), .testDone(ev[4]),
    .cmdReceived(ev[5]), .respSent(ev[6]), .busyTimeout(ev[7]), .testFail,
    .connectionOpenedFlags, .connDataRequest, .hostXferActive, .runIndicator, .readyIndicator,
    .activityIndicator, .connectionOpenIndicators, .connDataGrant, .loopTestActiveIndicator,
    .loopFaultIndicator, .ramTestActiveIndicator, .ramFaultIndicator, .romTestActiveIndicator,
    .romFaultIndicator, .commFaultIndicator, .hostTransferIndicator, .watchdogFaultFlag,
    .bankSelectSignal, .networkConnected, .irq);
  nmsm_host_model i_host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata);

  task automatic finish_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rdVal);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, rdVal);
    check(rdVal & m, exp);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    #40000;
    fail_count++;
    finish_test;
  end

  initial begin
    #8 rstn = 1'b1;
    cyc(5);
    rdc(`NMSM_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(`NMSM_ADDR_STATUS, 32'hFFFFFFFF, 32'h1);
    check(32'(hresp), 32'h0);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    wr(`NMSM_ADDR_CTRL, 32'h100);
    cyc(2);
    check(32'(bankSelectSignal), 32'h1);
    rdc(`NMSM_ADDR_STATUS, 32'hFFFFFFFF, 32'h1001);
    connectionOpenedFlags <= 8'hA5;
    connDataRequest <= 8'hFF;
    wr(`NMSM_ADDR_CTRL, 32'h400);
    cyc(4);
    check(32'(connectionOpenIndicators), 32'hA5);
    check(32'(connDataGrant), 32'hA5);
    check(32'(readyIndicator), 32'h1);
    check(32'(networkConnected), 32'h1);
    rdc(`NMSM_ADDR_CONN, 32'hFF, 32'hA5);
    for (i = 0; i < 3; i++) begin
      pulse(st[i]);
      cyc(2);
      check(32'(activityIndicator), 32'h1);
      pulse(en[i]);
      cyc(2);
      check(32'(activityIndicator), 32'h0);
    end
    hostXferActive <= 1'b1;
    cyc(2);
    check(32'(hostTransferIndicator), 32'h1);
    hostXferActive <= 1'b0;
    cyc(2);
    check(32'(hostTransferIndicator), 32'h0);
    wr(`NMSM_ADDR_CTRL, 32'h0);
    wr(`NMSM_ADDR_CTRL, 32'h480);
    cyc(5);
    check(32'(readyIndicator), 32'h0);
    cyc(30);
    check(32'(readyIndicator), 32'h1);
    testFail <= 1'b1;
    for (i = 2; i < 5; i++) begin
      wr(`NMSM_ADDR_CTRL, 32'h400 | i);
      cyc(3);
      rdc(`NMSM_ADDR_STATUS, 32'hFFF, 32'h1 | (32'h40 << (2 * (i - 2))));
      ev[4] <= 1'b1;
      cyc(3);
      rdc(`NMSM_ADDR_STATUS, 32'hFFF, 32'h1 | (32'h80 << (2 * (i - 2))));
      ev[4] <= 1'b0;
    end
    testFail <= 1'b0;
    for (i = 0; i < 6; i++) begin
      wr(`NMSM_ADDR_CTRL, 32'h400 | md[i]);
      cyc(3);
      check(32'(networkConnected), 32'h0);
      rdc(`NMSM_ADDR_STATUS, 32'h2FC6, (md[i] == 1) ? 32'h2000 : 32'h0);
    end
    wr(`NMSM_ADDR_CTRL, 32'h400);
    pulse(3);
    cyc(1);
    check(32'(commFaultIndicator), 32'h1);
    wr(`NMSM_ADDR_CTRL, 32'h600);
    pulse(3);
    cyc(1);
    check(32'(commFaultIndicator), 32'h0);
    wr(`NMSM_ADDR_CTRL, 32'h400);
    wr(`NMSM_ADDR_IRQ_MASK, 32'h2);
    cyc(2);
    check(32'(irq), 32'h1);
    wr(`NMSM_ADDR_IRQ_STAT, 32'h2);
    cyc(2);
    check(32'(irq), 32'h0);
    wr(`NMSM_ADDR_IRQ_MASK, 32'h1);
    pulse(0);
    cyc(1);
    check(32'(runIndicator), 32'h0);
    check(32'(irq), 32'h1);
    rdc(`NMSM_ADDR_STATUS, 32'h9, 32'h8);
    finish_test;
  end
endmodule
`default_nettype wire
